// [hw/swl_pkg.sv]
/*
 * package of the standby wake-up level select block: register offsets,
 * field positions, selector and record codes, reset values, carrier types.
 * assumes a byte-addressed register port with 32-bit data.
 */
package swl_pkg;

	// ------------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------------
	localparam int SWL_CHANS = 8;
	localparam int SWL_LANES = 4;
	localparam int SWL_AW = 8;
	localparam int SWL_DW = 32;

	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] SWL_OFS_CTRL_LOW = 8'h00;
	localparam logic [7:0] SWL_OFS_CTRL_HIGH = 8'h04;
	localparam logic [7:0] SWL_OFS_CLEAR = 8'h08;
	localparam logic [7:0] SWL_OFS_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] SWL_OFS_IRQ_MASK = 8'h10;

	// ------------------------------------------------------------------
	// field positions inside one byte lane
	// ------------------------------------------------------------------
	localparam int SWL_LANE_W = 8;
	localparam int SWL_POS_EN = 0;
	localparam int SWL_POS_UNDEF = 1;
	localparam int SWL_POS_REC = 2;
	localparam int SWL_POS_SEL = 4;
	localparam int SWL_POS_ZERO = 7;

	// ------------------------------------------------------------------
	// selector and edge-record codes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		SWL_SEL_LOW = 3'h0,
		SWL_SEL_HIGH = 3'h1,
		SWL_SEL_FALL = 3'h2,
		SWL_SEL_RISE = 3'h3,
		SWL_SEL_BOTH = 3'h4
	} swl_sel_t;

	localparam logic [1:0] SWL_REC_NONE = 2'h0;
	localparam logic [1:0] SWL_REC_RISE = 2'h1;
	localparam logic [1:0] SWL_REC_FALL = 2'h2;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [2:0] SWL_RST_SEL = 3'h2;
	localparam logic SWL_RST_EN = 1'b0;
	localparam logic SWL_RST_UNDEF = 1'b0;
	localparam logic [7:0] SWL_RST_MASK = 8'h00;
	localparam logic [2:0] SWL_RST_SYNC = 3'h0;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [SWL_AW-1:0] addr;
		logic [SWL_DW-1:0] wdata;
		logic we;
		logic re;
	} swl_bus_req_t;

	typedef struct packed {
		logic [2:0] sel;
		logic en;
	} swl_chan_cfg_t;

endpackage

// [hw/swl_chan.sv]
/*
 * one wake-up channel: pin synchroniser with agreement filter, level or
 * edge detection, one request pulse per condition, edge record.
 * assumes clk, synchronised reset and clock enable from the top.
 */
`timescale 1ns/10ps
module swl_chan import swl_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic pin,
	input wire swl_chan_cfg_t cfg,
	input wire logic clr,
	output logic req,
	output logic [1:0] rec
);

	typedef struct packed {
		logic [2:0] sync;
		logic filt;
		logic lvl_prev;
		logic req;
		logic [1:0] rec;
	} swl_chan_st_t;

	swl_chan_st_t st_q;
	swl_chan_st_t st_d;

	logic new_filt;
	logic rise;
	logic fall;
	logic lvl_hit;
	logic edge_hit;

	always_comb begin
		st_d = st_q;
		st_d.sync = {st_q.sync[1:0], pin};
		// only stages two and three are looked at; stage one is metastable
		new_filt = (st_q.sync[1] == st_q.sync[2]) ? st_q.sync[2] : st_q.filt;
		st_d.filt = new_filt;
		rise = new_filt & ~st_q.filt;
		fall = ~new_filt & st_q.filt;
		lvl_hit = 1'b0;
		edge_hit = 1'b0;
		case (cfg.sel)
			SWL_SEL_LOW: lvl_hit = ~new_filt;
			SWL_SEL_HIGH: lvl_hit = new_filt;
			SWL_SEL_FALL: edge_hit = fall;
			SWL_SEL_RISE: edge_hit = rise;
			SWL_SEL_BOTH: edge_hit = rise | fall;
			default: begin
				lvl_hit = 1'b0;
				edge_hit = 1'b0;
			end
		endcase
		// level modes fire once on entry, not every cycle the level stands
		st_d.lvl_prev = cfg.en & lvl_hit;
		st_d.req = cfg.en & (edge_hit | (lvl_hit & ~st_q.lvl_prev));
		// a new edge in the clearing cycle survives the clear
		st_d.rec = clr ? SWL_REC_NONE : st_q.rec;
		if (cfg.en && cfg.sel == SWL_SEL_BOTH) begin
			if (rise) begin
				st_d.rec = st_d.rec | SWL_REC_RISE;
			end
			if (fall) begin
				st_d.rec = st_d.rec | SWL_REC_FALL;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign req = st_q.req;
	assign rec = st_q.rec;

endmodule

// [hw/swl_top.sv]
/*
 * standby wake-up level select: two control words of four channels each,
 * per-channel clear, sticky wake status with mask and one interrupt line.
 * assumes a simple register port (strobes one cycle, read data next
 * cycle), external pins asynchronous to CLK, CE gating all state but the reset synchroniser.
 */
`timescale 1ns/10ps

// Overview of operation
// - selector picks low, high, fall, rise, both
// - read-only two-bit edge record per channel
// - record valid only under either-edge selector
// - record captures edge that caused release
// - channel clear also clears edge record
// - enable zero blocks release, one allows
// - low word selectors at 30-28,22-20,14-12,6-4
// - records 27-26..3-2, enables bits 24,16,8,0
// - lane top bit zero, bit one undefined
// - high word holds channels 7-4 alike
module swl_top import swl_pkg::*; (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [SWL_AW-1:0] ADDR,
	input wire logic [SWL_DW-1:0] WDATA,
	input wire logic WE,
	input wire logic RE,
	output logic [SWL_DW-1:0] RDATA,
	input wire logic [SWL_CHANS-1:0] WAKE_PIN,
	output logic [SWL_CHANS-1:0] WAKE_REQ,
	output logic IRQ
);

	// ------------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;

	// reset synchroniser stays outside CE so release is never held off
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		swl_chan_cfg_t [SWL_CHANS-1:0] cfg;
		logic [SWL_CHANS-1:0] undef;
		logic [SWL_CHANS-1:0] status;
		logic [SWL_CHANS-1:0] mask;
		logic [SWL_CHANS-1:0] clr;
		logic [SWL_DW-1:0] rdata;
		logic [SWL_CHANS-1:0] wake;
		logic irq;
	} swl_state_t;

	swl_state_t st_q;
	swl_state_t st_d;

	swl_bus_req_t bus;
	logic [SWL_CHANS-1:0] chan_req;
	logic [SWL_CHANS-1:0][1:0] chan_rec;

	assign bus.addr = ADDR;
	assign bus.wdata = WDATA;
	assign bus.we = WE;
	assign bus.re = RE;

	// ------------------------------------------------------------------
	// channels
	// ------------------------------------------------------------------
	generate
		for (genvar c = 0; c < SWL_CHANS; c++) begin : g_chan
			swl_chan u_chan (
				.clk(CLK),
				.rst_n(rst_sync_q),
				.ce(CE),
				.pin(WAKE_PIN[c]),
				.cfg(st_q.cfg[c]),
				.clr(st_q.clr[c]),
				.req(chan_req[c]),
				.rec(chan_rec[c])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// lane packing
	// ------------------------------------------------------------------
	function automatic logic [SWL_LANE_W-1:0] lane_read(
		input swl_chan_cfg_t cfg,
		input logic [1:0] rec,
		input logic undef
	);
		logic [SWL_LANE_W-1:0] v;
		v = '0;
		v[SWL_POS_ZERO] = 1'b0;
		v[SWL_POS_SEL +: 3] = cfg.sel;
		v[SWL_POS_REC +: 2] = rec;
		v[SWL_POS_UNDEF] = undef;
		v[SWL_POS_EN] = cfg.en;
		return v;
	endfunction

	function automatic swl_chan_cfg_t lane_write(
		input logic [SWL_LANE_W-1:0] v
	);
		swl_chan_cfg_t cfg;
		cfg.sel = v[SWL_POS_SEL +: 3];
		cfg.en = v[SWL_POS_EN];
		return cfg;
	endfunction

	// ------------------------------------------------------------------
	// register file and event logic
	// ------------------------------------------------------------------
	logic [SWL_CHANS-1:0] wr_status_clr;
	logic [SWL_CHANS-1:0] wr_chan_clr;
	logic [SWL_DW-1:0] rd_word;
	logic hit_low;
	logic hit_high;

	always_comb begin
		st_d = st_q;
		hit_low = bus.addr == SWL_OFS_CTRL_LOW;
		hit_high = bus.addr == SWL_OFS_CTRL_HIGH;
		wr_status_clr = '0;
		wr_chan_clr = '0;
		rd_word = '0;

		// control words: each write takes both selector and enable as
		// given; ordering of selector before enable is left to software
		if (bus.we && hit_low) begin
			for (int l = 0; l < SWL_LANES; l++) begin
				st_d.cfg[l] = lane_write(bus.wdata[l*SWL_LANE_W +: SWL_LANE_W]);
			end
		end
		if (bus.we && hit_high) begin
			for (int l = 0; l < SWL_LANES; l++) begin
				st_d.cfg[SWL_LANES+l] =
					lane_write(bus.wdata[l*SWL_LANE_W +: SWL_LANE_W]);
			end
		end
		if (bus.we && bus.addr == SWL_OFS_CLEAR) begin
			wr_chan_clr = bus.wdata[SWL_CHANS-1:0];
		end
		if (bus.we && bus.addr == SWL_OFS_IRQ_STATUS) begin
			wr_status_clr = bus.wdata[SWL_CHANS-1:0];
		end
		if (bus.we && bus.addr == SWL_OFS_IRQ_MASK) begin
			st_d.mask = bus.wdata[SWL_CHANS-1:0];
		end

		// forbidden selector codes are stored as written; such a channel
		// simply never fires
		st_d.clr = wr_chan_clr;

		// sticky status: a request in the clearing cycle keeps its bit
		st_d.status = (st_q.status & ~wr_status_clr & ~wr_chan_clr) | chan_req;
		st_d.wake = chan_req;
		st_d.irq = |(st_d.status & st_d.mask);

		// read path: data valid in the cycle after the strobe only
		if (bus.re) begin
			if (hit_low) begin
				for (int l = 0; l < SWL_LANES; l++) begin
					rd_word[l*SWL_LANE_W +: SWL_LANE_W] =
						lane_read(st_q.cfg[l], chan_rec[l], st_q.undef[l]);
				end
			end else if (hit_high) begin
				for (int l = 0; l < SWL_LANES; l++) begin
					rd_word[l*SWL_LANE_W +: SWL_LANE_W] = lane_read(st_q.cfg[SWL_LANES+l],
						chan_rec[SWL_LANES+l], st_q.undef[SWL_LANES+l]);
				end
			end else if (bus.addr == SWL_OFS_IRQ_STATUS) begin
				rd_word[SWL_CHANS-1:0] = st_q.status;
			end else if (bus.addr == SWL_OFS_IRQ_MASK) begin
				rd_word[SWL_CHANS-1:0] = st_q.mask;
			end else begin
				// clear register is write-only; unmapped offsets read zero
				rd_word = '0;
			end
		end
		st_d.rdata = rd_word;
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			for (int c = 0; c < SWL_CHANS; c++) begin
				st_q.cfg[c].sel <= SWL_RST_SEL;
				st_q.cfg[c].en <= SWL_RST_EN;
			end
			st_q.undef <= {SWL_CHANS{SWL_RST_UNDEF}};
			st_q.status <= '0;
			st_q.mask <= SWL_RST_MASK;
			st_q.clr <= '0;
			st_q.rdata <= '0;
			st_q.wake <= '0;
			st_q.irq <= 1'b0;
		end else if (CE) begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign RDATA = st_q.rdata;
	assign WAKE_REQ = st_q.wake;
	assign IRQ = st_q.irq;

endmodule

// [tb/swl_props.sv]
/* assertions on the ports of swl_top.
 * assumes CE drops only around a write that must be ignored; bound below. */
`timescale 1ns/10ps
module swl_props import swl_pkg::*; (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [SWL_AW-1:0] ADDR,
	input wire logic [SWL_DW-1:0] WDATA,
	input wire logic WE,
	input wire logic RE,
	input wire logic [SWL_DW-1:0] RDATA,
	input wire logic [SWL_CHANS-1:0] WAKE_PIN,
	input wire logic [SWL_CHANS-1:0] WAKE_REQ,
	input wire logic IRQ
);
	// ----------------
	// quiet counter
	// ----------------
	// cycles since a pin moved or a write; a request needs one of them
	logic [3:0] quiet_q;
	logic [SWL_CHANS-1:0] pin_q;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			quiet_q <= 4'h0;
			pin_q <= '0;
		end else begin
			pin_q <= WAKE_PIN;
			quiet_q <= (WE || pin_q != WAKE_PIN) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// ----------------
	// properties
	// ----------------
	rd_idle_a: assert property ($past(CE) && !$past(RE) |-> RDATA == '0)
		else $error("read data outside read cycle");
	rsv_bits_a: assert property ($past(RE) && $past(ADDR) < SWL_OFS_CLEAR |->
		(RDATA & 32'h82828282) == '0)
		else $error("reserved bits not zero");
	sel_back_a: assert property (WE && ADDR < 8'h08 ##2 RE && ADDR == $past(ADDR, 2)
		|=> (RDATA & 32'h71717171) == ($past(WDATA, 3) & 32'h71717171))
		else $error("selector or enable read back wrong");
	unmap_rd_a: assert property (RE && ADDR > SWL_OFS_IRQ_MASK |=> RDATA == '0)
		else $error("unmapped read not zero");
	req_pulse_a: assert property (WAKE_REQ != '0 |=> (WAKE_REQ & $past(WAKE_REQ)) == '0)
		else $error("request longer than one cycle");
	quiet_a: assert property (quiet_q > 4'h9 |-> WAKE_REQ == '0)
		else $error("request without cause");
	irq_rise_a: assert property ($rose(IRQ) |-> WAKE_REQ != '0
		|| $past(WAKE_REQ) != '0 || $past(WE) || $past(WE, 2))
		else $error("interrupt raised without event");
	irq_fall_a: assert property ($fell(IRQ) |-> $past(WE) || $past(WE, 2))
		else $error("interrupt dropped without clear");
	req_cov_c: cover property (WAKE_REQ != '0);
	irq_cov_c: cover property ($rose(IRQ));
	back_cov_c: cover property (WE ##2 RE);
endmodule
bind swl_top swl_props u_swl_props (.CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR),
	.WDATA(WDATA), .WE(WE), .RE(RE), .RDATA(RDATA), .WAKE_PIN(WAKE_PIN),
	.WAKE_REQ(WAKE_REQ), .IRQ(IRQ));

// [tb/swl_pins.sv]
/* far side: external wake pins, levels moving off the clock edge.
 * assumes the bench gives the wanted level and picks prompt or slow. */
`timescale 1ns/10ps
module swl_pins (
	input wire logic clk,
	input wire logic slow,
	input wire logic [7:0] want,
	output logic [7:0] pin
);
	logic [7:0] lag_q = 8'h00;
	logic [7:0] pin_q = 8'h00;
	// mid-cycle moves, so the synchroniser sees real asynchronous pins
	always @(posedge clk) begin
		lag_q <= want;
		pin_q <= #7 slow ? lag_q : want;
	end
	assign pin = pin_q;
endmodule

// [tb/tb_top.sv]
/* self-checking bench of swl_top with random channel set-up.
 * assumes swl_pins on the pins; CE dropped once around an ignored write. */
`timescale 1ns/10ps
module tb_top import swl_pkg::*; ;
	logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, slow = 1'b0, ce = 1'b1, irq;
	logic [7:0] addr = 8'h00, want = 8'h00, pin, req;
	logic [31:0] wdata = 32'h0, rdata, rdat;
	int error_cnt = 0, n_compared = 0, seed = 11466, npulse = 0, cyc = 0;
	always #12.5 clk = ~clk;
	swl_pins u_swl_pins (.clk(clk), .slow(slow), .want(want), .pin(pin));
	swl_top u_swl_top (.CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata),
		.WE(we), .RE(re), .RDATA(rdata), .WAKE_PIN(pin), .WAKE_REQ(req), .IRQ(irq));
	// ----------------
	// checking and bus
	// ----------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// trailing idle edge: no strobe is lowered and raised in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 rdat = rdata;
		@(posedge clk);
	endtask
	task automatic wrd(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		rd(a);
		chk(rdat & 32'h71717171, d & 32'h71717171);
	endtask
	always @(posedge clk) begin
		npulse <= npulse + $countones(req);
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			summarize();
		end
	end
	// ----------------
	// main sequence
	// ----------------
	initial begin
		logic [31:0] v;
		logic [7:0] a;
		logic [2:0] s;
		int ch;
		int n0;
		int l;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(SWL_OFS_CTRL_LOW);
		chk(rdat, 32'h20202020);
		rd(SWL_OFS_CTRL_HIGH);
		chk(rdat, 32'h20202020);
		rd(8'h40);
		chk(rdat, 32'h0);
		repeat (6) begin
			for (l = 0; l < 32; l += 8) v[l+:8] = {1'b0, 3'({$random(seed)} % 5), 4'h0};
			a = $random(seed) & 1 ? SWL_OFS_CTRL_HIGH : SWL_OFS_CTRL_LOW;
			wrd(a, v);
			wrd(a, v | (32'h01010101 & $random(seed)));
		end
		// a write while CE is low must leave the word untouched
		wrd(SWL_OFS_CTRL_LOW, 32'h20202020);
		ce <= 1'b0;
		wr(SWL_OFS_CTRL_LOW, 32'h11111111);
		ce <= 1'b1;
		@(posedge clk);
		rd(SWL_OFS_CTRL_LOW);
		chk(rdat, 32'h20202020);
		for (int m = 0; m < 6; m++) begin
			ch = {$random(seed)} % 8;
			a = ch > 3 ? SWL_OFS_CTRL_HIGH : SWL_OFS_CTRL_LOW;
			s = m > 4 ? 3'h4 : 3'(m);
			v = 32'h20202020;
			v[8*(ch%4)+4+:3] = s;
			wrd(SWL_OFS_CTRL_LOW, 32'h20202020);
			wrd(SWL_OFS_CTRL_HIGH, 32'h20202020);
			want <= 8'h00;
			wr(SWL_OFS_IRQ_STATUS, 32'hff);
			wr(SWL_OFS_IRQ_MASK, m == 3 ? 32'h0 : 32'hff);
			want[ch] <= s == 3'h0;
			repeat (8) @(posedge clk);
			wrd(a, v);
			wrd(a, v | 32'(m < 5) << 8*(ch%4));
			n0 = npulse;
			slow <= m[0];
			repeat (12) @(posedge clk);
			want[ch] <= s != 3'h0;
			repeat (12) @(posedge clk);
			want[ch] <= s == 3'h0;
			repeat (12) @(posedge clk);
			chk(npulse - n0, m > 4 ? 0 : s == 3'h4 ? 2 : 1);
			chk(irq, m < 5 && m != 3);
			rd(SWL_OFS_IRQ_STATUS);
			chk(rdat, 32'(m < 5) << ch);
			rd(a);
			if (m > 3)
				chk(rdat[8*(ch%4)+2+:2], m == 4 ? 2'h3 : 2'h0);
			wr(SWL_OFS_CLEAR, 32'h1 << ch);
			rd(a);
			chk(rdat[8*(ch%4)+2+:2], 2'h0);
			chk(irq, 1'b0);
		end
		summarize();
	end
endmodule
